// File: tb/can_transceiver_mode_controller_tb.sv
// Self-checking bench for the transceiver mode controller.
// Assumes short startup and silence counts; inputs change at the falling edge.
`timescale 1ns/1ps

module can_transceiver_mode_controller_tb
  import mode_ctrl_pkg::*;
();
  localparam int SU = 20;
  localparam int SIL = 30;
  typedef struct packed {logic nrm, uv, poff, ota, otr; logic [1:0] m; logic con, tx;} row_s;
  // nrm uv poff ota otr | mode connect tx
  row_s rows [10] = '{'{1,1,0,0,0,1,1,0}, '{1,0,0,0,0,2,1,1}, '{1,1,0,0,0,1,1,0}, '{1,0,0,0,0,2,1,1},
    '{0,0,0,0,0,1,1,0}, '{1,0,0,0,0,2,1,1}, '{1,1,0,1,0,3,0,0}, '{0,0,0,0,1,1,1,0},
    '{0,0,0,1,0,3,0,0}, '{0,0,1,1,1,0,0,0}};
  logic clk = 1'b0, rst = 1'b1, want = 1'b0, bus_act = 1'b0, uv = 1'b0, pon = 1'b0;
  logic poff = 1'b0, ota = 1'b0, otr = 1'b0, wake = 1'b0;
  logic sel_n, bus_rx, rxd_out, tx_en, rx_en, con, bias, sup;
  logic [1:0] mode_out;
  int errors = 0, total_checks = 0, n;

  always #4 clk = ~clk;

  mcu_bus_model far (.clk(clk), .want_normal(want), .bus_active(bus_act), .standby_select_n(sel_n), .bus_rx(bus_rx));

  can_transceiver_mode_controller #(.STARTUP_CYCLES(SU), .SILENCE_CYCLES(SIL)) dut (.clk(clk), .rst(rst),
    .standby_select_n(sel_n), .txd_in(1'b1), .rxd_out(rxd_out), .io_undervoltage(uv),
    .battery_power_on(pon), .battery_power_off(poff), .overtemp_activate(ota), .overtemp_release(otr),
    .bus_rx(bus_rx), .bus_wake_pattern(wake), .bus_tx_enable(tx_en), .bus_rx_enable(rx_en),
    .bus_connect(con), .bus_bias_mid(bias), .transceiver_supply_on(sup), .mode_out(mode_out));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int k;
    k = 0;
    while (mode_out !== m && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    chk("mode", m, mode_out);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Far above the few hundred cycles the sequence needs
  initial
  begin
    repeat (4000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge clk);
    chk("reset mode", MODE_OFF_S, mode_out);
    chk("reset rxd", 1, rxd_out);
    rst = 1'b0;
    pon = 1'b1;
    wait_mode(MODE_STANDBY_S);
    chk("power-on rxd", 0, rxd_out);
    chk("supply", 0, sup);
    foreach (rows[i])
    begin
      {want, uv, poff, ota, otr} = {rows[i].nrm, rows[i].uv, rows[i].poff, rows[i].ota, rows[i].otr};
      @(negedge clk);
      chk("row mode", rows[i].m, mode_out);
      chk("row connect", rows[i].con, con);
      chk("row tx", rows[i].tx, tx_en);
      chk("row rx", rows[i].tx, rx_en);
      if (rows[i].m != MODE_STANDBY_S)
        chk("row supply", rows[i].m == MODE_NORMAL_S, sup);
    end
    {poff, ota, otr, want} = 4'h0;
    wait_mode(MODE_STANDBY_S);
    chk("rxd held", 0, rxd_out);
    want = 1'b1;
    repeat (2) @(negedge clk);
    chk("rxd follows bus", bus_rx, rxd_out);
    want = 1'b0;
    repeat (2) @(negedge clk);
    chk("rxd idle", 1, rxd_out);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    chk("wake supply", 1, sup);
    chk("wake rxd", 0, rxd_out);
    n = 0;
    while (sup === 1'b1 && n < SIL + 10)
    begin
      @(negedge clk);
      n++;
    end
    chk("supply timeout", 1, n == SIL);
    ota = 1'b1;
    @(negedge clk);
    chk("ot rxd", 0, rxd_out);
    {ota, otr} = 2'h1;
    @(negedge clk);
    chk("released", MODE_STANDBY_S, mode_out);
    chk("pending rxd", 0, rxd_out);
    otr = 1'b0;
    repeat (SIL + 5) @(negedge clk);
    chk("silent bias", 0, bias);
    bus_act = 1'b1;
    repeat (12) @(negedge clk);
    chk("active bias", 1, bias);
    repeat (3 * SIL) @(negedge clk);
    chk("timer restart", 1, bias);
    bus_act = 1'b0;
    repeat (SIL + 5) @(negedge clk);
    chk("silent again", 0, bias);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("mid reset mode", MODE_OFF_S, mode_out);
    chk("mid reset rxd", 1, rxd_out);
    chk("mid reset supply", 0, sup);
    wait_mode(MODE_STANDBY_S);
    chk("restart rxd", 0, rxd_out);
    tally_and_finish();
  end
endmodule

// File: tb/mcu_bus_model.sv
// Far-side model: the microcontroller's select pin and a toggling bus line.
// Assumes the bench drives its controls at the falling edge of clk.
`timescale 1ns/1ps

module mcu_bus_model
(
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic want_normal,
  input wire logic bus_active,
  // Toward the controller
  output logic standby_select_n,
  output logic bus_rx
);
  logic [2:0] tick_q;

  // --------------------------------------------------------------------------
  // Mode request
  // --------------------------------------------------------------------------
  // Level request: high asks for Normal, low for Standby
  assign standby_select_n = want_normal;

  // --------------------------------------------------------------------------
  // Bus traffic
  // --------------------------------------------------------------------------
  // Edges every eight cycles, well inside the silence window of the bench
  initial
  begin
    tick_q = 3'h0;
    bus_rx = 1'b1;
  end
  always @(negedge clk)
  begin
    if (bus_active)
    begin
      tick_q <= tick_q + 3'h1;
      if (tick_q == 3'h7)
        bus_rx <= ~bus_rx;
    end
  end
endmodule

// File: verilog/can_transceiver_mode_controller.sv
// System mode controller for a battery-supplied CAN transceiver.
// Assumes all threshold flags are already synchronous to clk.
//
// What this block does
// - One state machine, four modes
// - Standby to Normal on select high, IO ok
// - Normal to Standby on select low
// - Normal to Standby on IO undervoltage
// - Overtemp entered at once from Normal/Standby
// - Battery power-off enters Off from anywhere
// - Power-on, startup delay, then Standby
// - Receive-data low from Off exit until Normal
// - Standby: no bus traffic, wake watch only
// - Standby bias: ground when silent, else mid
// - Standby wake-up forces receive-data low
// - Off: bus pins disconnected, high impedance
// - Overtemp: bus off, pins floating, supply off
// - Overtemp: no new wakes, pending persists
// - Overtemp to Standby on temperature release
// - Power-off beats release in Overtemp
// - Wake switches supply on, timeout off
// - Select high in Standby switches supply on
// - Silence timer restarts on every bus edge
`timescale 1ns/1ps
`include "mode_ctrl_map.svh"

module can_transceiver_mode_controller
  import mode_ctrl_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int SILENCE_CYCLES = `SILENCE_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Microcontroller side
  input wire logic standby_select_n,
  input wire logic txd_in,
  output logic rxd_out,
  // Threshold flags
  input wire logic io_undervoltage,
  input wire logic battery_power_on,
  input wire logic battery_power_off,
  input wire logic overtemp_activate,
  input wire logic overtemp_release,
  // Bus side
  input wire logic bus_rx,
  input wire logic bus_wake_pattern,
  output logic bus_tx_enable,
  output logic bus_rx_enable,
  output logic bus_connect,
  output logic bus_bias_mid,
  output logic transceiver_supply_on,
  output logic [1:0] mode_out
);

  op_mode_e mode_q, mode_d;
  logic [31:0] startup_cnt_q;
  logic [31:0] silence_cnt_q;
  logic [31:0] supply_cnt_q;
  logic bus_rx_q;
  logic bus_silent_q;
  logic power_on_flag_q;
  logic wake_pending_q;
  logic supply_q;
  logic bus_edge;

  assign bus_edge = bus_rx != bus_rx_q;

  // ----------------------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------------------
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_OFF_S:
      begin
        if (!battery_power_off && startup_cnt_q >= 32'(STARTUP_CYCLES))
          mode_d = MODE_STANDBY_S;
      end
      MODE_STANDBY_S:
      begin
        if (battery_power_off)
          mode_d = MODE_OFF_S;
        else if (overtemp_activate)
          mode_d = MODE_OVERTEMP_S;
        else if (standby_select_n && !io_undervoltage)
          mode_d = MODE_NORMAL_S;
      end
      MODE_NORMAL_S:
      begin
        if (battery_power_off)
          mode_d = MODE_OFF_S;
        else if (overtemp_activate)
          mode_d = MODE_OVERTEMP_S;
        else if (io_undervoltage)
          mode_d = MODE_STANDBY_S;
        else if (!standby_select_n)
          mode_d = MODE_STANDBY_S;
      end
      MODE_OVERTEMP_S:
      begin
        if (battery_power_off)
          mode_d = MODE_OFF_S;
        else if (overtemp_release)
          mode_d = MODE_STANDBY_S;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mode_q <= MODE_OFF_S;
    else
      mode_q <= mode_d;
  end

  // ----------------------------------------------------------------------------
  // Startup delay after power-on
  // ----------------------------------------------------------------------------
  // Counting only while power-on holds; a dip restarts initialization
  always_ff @(posedge clk)
  begin
    if (rst)
      startup_cnt_q <= 32'h0;
    else if (mode_q != MODE_OFF_S || !battery_power_on || battery_power_off)
      startup_cnt_q <= 32'h0;
    else if (startup_cnt_q < 32'(STARTUP_CYCLES))
      startup_cnt_q <= startup_cnt_q + 32'h1;
  end

  // ----------------------------------------------------------------------------
  // Bus silence timer
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus_rx_q <= 1'b1;
      silence_cnt_q <= 32'h0;
      bus_silent_q <= 1'b1;
    end
    else
    begin
      bus_rx_q <= bus_rx;
      if (bus_edge)
      begin
        silence_cnt_q <= 32'h0;
        bus_silent_q <= 1'b0;
      end
      else if (silence_cnt_q < 32'(SILENCE_CYCLES))
        silence_cnt_q <= silence_cnt_q + 32'h1;
      else
        bus_silent_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Power-on and wake-up indications
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      power_on_flag_q <= 1'b0;
    else if (mode_q == MODE_OFF_S && mode_d == MODE_STANDBY_S)
      power_on_flag_q <= 1'b1;
    else if (mode_d == MODE_NORMAL_S)
      power_on_flag_q <= 1'b0;
  end

  // Wake detection only in Standby; Overtemp keeps what is already pending
  always_ff @(posedge clk)
  begin
    if (rst)
      wake_pending_q <= 1'b0;
    else if (mode_d == MODE_OFF_S || mode_d == MODE_NORMAL_S)
      wake_pending_q <= 1'b0;
    else if (mode_q == MODE_STANDBY_S && bus_wake_pattern)
      wake_pending_q <= 1'b1;
  end

  // ----------------------------------------------------------------------------
  // Internal transceiver supply
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      supply_q <= 1'b0;
      supply_cnt_q <= 32'h0;
    end
    else if (mode_d == MODE_NORMAL_S)
    begin
      supply_q <= 1'b1;
      supply_cnt_q <= 32'h0;
    end
    else if (mode_d != MODE_STANDBY_S)
    begin
      supply_q <= 1'b0;
      supply_cnt_q <= 32'h0;
    end
    else if (standby_select_n)
    begin
      supply_q <= 1'b1;
      supply_cnt_q <= 32'h0;
    end
    else if (bus_wake_pattern && mode_q == MODE_STANDBY_S)
    begin
      supply_q <= 1'b1;
      supply_cnt_q <= 32'h0;
    end
    else if (supply_q)
    begin
      if (supply_cnt_q >= 32'(SILENCE_CYCLES) - 32'h1)
      begin
        supply_q <= 1'b0;
        supply_cnt_q <= 32'h0;
      end
      else
        supply_cnt_q <= supply_cnt_q + 32'h1;
    end
  end

  // Pin taken from the flop itself so a wake shows on the next edge, not one later
  assign transceiver_supply_on = supply_q;

  // ----------------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxd_out <= 1'b1;
      bus_tx_enable <= 1'b0;
      bus_rx_enable <= 1'b0;
      bus_connect <= 1'b0;
      bus_bias_mid <= 1'b0;
      mode_out <= `MODE_OFF;
    end
    else
    begin
      mode_out <= mode_d;
      bus_tx_enable <= mode_d == MODE_NORMAL_S;
      bus_rx_enable <= mode_d == MODE_NORMAL_S;
      bus_connect <= mode_d == MODE_NORMAL_S || mode_d == MODE_STANDBY_S;
      bus_bias_mid <= mode_d == MODE_NORMAL_S || (mode_d == MODE_STANDBY_S && !bus_silent_q);
      if (mode_d == MODE_NORMAL_S)
        rxd_out <= bus_rx;
      else
        rxd_out <= !(power_on_flag_q || wake_pending_q ||
                     (mode_q == MODE_OFF_S && mode_d == MODE_STANDBY_S) ||
                     (mode_q == MODE_STANDBY_S && bus_wake_pattern));
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_poweroff_to_off: assert property (@(posedge clk) disable iff (rst)
    battery_power_off |=> mode_q == MODE_OFF_S)
    else $error("power-off did not reach Off");

  a_overtemp_entry: assert property (@(posedge clk) disable iff (rst)
    (mode_q inside {MODE_NORMAL_S, MODE_STANDBY_S}) && overtemp_activate && !battery_power_off
    |=> mode_q == MODE_OVERTEMP_S)
    else $error("overtemp not entered at once");

  a_normal_entry: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_NORMAL_S && $past(mode_q) == MODE_STANDBY_S |-> $past(standby_select_n) && !$past(io_undervoltage))
    else $error("Normal entered without select or with undervoltage");

  a_normal_exit_uv: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_NORMAL_S && io_undervoltage && !battery_power_off && !overtemp_activate
    |=> mode_q == MODE_STANDBY_S)
    else $error("undervoltage did not force Standby");

  a_normal_exit_sel: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_NORMAL_S && !standby_select_n && !battery_power_off && !overtemp_activate
    |=> mode_q == MODE_STANDBY_S)
    else $error("select low did not give Standby");

  a_overtemp_outputs: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OVERTEMP_S |-> !transceiver_supply_on && !bus_connect && !bus_tx_enable)
    else $error("Overtemp outputs not off");

  a_off_release: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OVERTEMP_S && battery_power_off && overtemp_release |=> mode_q == MODE_OFF_S)
    else $error("release beat power-off");

  a_poweron_rxd: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OFF_S && mode_d == MODE_STANDBY_S |=> !rxd_out ##1 (mode_q == MODE_NORMAL_S || !rxd_out))
    else $error("power-on not shown on receive data");

  a_startup_wait: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_STANDBY_S && $past(mode_q) == MODE_OFF_S |-> $past(startup_cnt_q) >= 32'(STARTUP_CYCLES))
    else $error("left Off before startup delay");

  a_silence_bias: assert property (@(posedge clk) disable iff (rst)
    bus_edge |=> !bus_silent_q)
    else $error("bus edge did not clear silence");

  a_poweron_hold: assert property (@(posedge clk) disable iff (rst)
    power_on_flag_q && mode_q != MODE_NORMAL_S |-> !rxd_out)
    else $error("power-on flag not shown on receive data");

  a_off_outputs: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OFF_S |-> !bus_connect && !bus_bias_mid && !transceiver_supply_on)
    else $error("Off outputs not released");

  a_standby_quiet: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_STANDBY_S |-> !bus_tx_enable && !bus_rx_enable)
    else $error("bus data path enabled in Standby");

  a_silent_ground: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_STANDBY_S |-> bus_bias_mid == !$past(bus_silent_q))
    else $error("Standby bias does not follow bus activity");

  a_wake_rxd: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_STANDBY_S && bus_wake_pattern && mode_d != MODE_NORMAL_S |=> !rxd_out)
    else $error("wake-up not shown on receive data");

  a_overtemp_no_wake: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OVERTEMP_S && !wake_pending_q |=> !wake_pending_q)
    else $error("new wake taken in Overtemp");

  a_overtemp_wake_keep: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OVERTEMP_S && wake_pending_q |-> !rxd_out)
    else $error("pending wake lost in Overtemp");

  a_release_standby: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OVERTEMP_S && overtemp_release && !battery_power_off |=> mode_q == MODE_STANDBY_S)
    else $error("release did not give Standby");

  a_select_supply: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_STANDBY_S && standby_select_n && mode_d == MODE_STANDBY_S |=> transceiver_supply_on)
    else $error("select high did not switch supply on");

  a_wake_supply: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_STANDBY_S && bus_wake_pattern && mode_d == MODE_STANDBY_S |=> transceiver_supply_on)
    else $error("wake did not switch supply on");

  a_overtemp_quiet: assert property (@(posedge clk) disable iff (rst)
    mode_q == MODE_OVERTEMP_S |-> !bus_rx_enable && !bus_bias_mid)
    else $error("receiver or bias active in Overtemp");

endmodule

// File: verilog/mode_ctrl_map.svh
// Constants for the transceiver mode controller: mode codes, timing counts.
// Assumes a 125 MHz clk; included by bare name.
`ifndef MODE_CTRL_MAP_SVH
`define MODE_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 8

// ----------------------------------------------------------------------------
// Timing (times in microseconds, counts derived)
// ----------------------------------------------------------------------------
`define STARTUP_DELAY_US 2800
`define STARTUP_CYCLES ((`STARTUP_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define SILENCE_TIMEOUT_US 1000
`define SILENCE_CYCLES ((`SILENCE_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------------
`define MODE_OFF 2'h0
`define MODE_STANDBY 2'h1
`define MODE_NORMAL 2'h2
`define MODE_OVERTEMP 2'h3

`endif

// File: verilog/mode_ctrl_pkg.sv
// Types for the transceiver mode controller.
// Assumes mode_ctrl_map.svh is on the include path.
`include "mode_ctrl_map.svh"

package mode_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_OFF_S = `MODE_OFF,
    MODE_STANDBY_S = `MODE_STANDBY,
    MODE_NORMAL_S = `MODE_NORMAL,
    MODE_OVERTEMP_S = `MODE_OVERTEMP
  } op_mode_e;
endpackage
